// file: rtl/pstage_defines.svh
// Purpose: Offsets, widths, reset values, mode codes and counts for the power-stage block
// Assumes: Included by its bare name
// Notes: Sixteen-bit register port, one register per address
`ifndef PSTAGE_DEFINES_SVH
`define PSTAGE_DEFINES_SVH

`define ADDR_W 4
`define DATA_W 16
`define CMP_W 12

`define OFF_CONFIG 4'h0
`define OFF_SET_A 4'h1
`define OFF_RST_A 4'h2
`define OFF_SET_B 4'h3
`define OFF_RST_B 4'h4
`define OFF_OUT_CFG 4'h5
`define OFF_IN_CTL_A 4'h6
`define OFF_IN_CTL_B 4'h7
`define OFF_STATUS 4'h8

`define RST_CMP 12'h000
`define RST_CONFIG 5'h00
`define RST_OUT_CFG 5'h13
`define RST_IN_CTL 8'h00

`define MODE_NONE 4'h0
`define MODE_LAST_LEVEL 4'h7
`define MODE_EDGE_RETRIG 4'h8
`define MODE_FIX_RETRIG 4'h9
`define MODE_FIX_RETRIG_OFF 4'hE

`define FILT_LAST 2'h3
`define DT4_EXTRA 12'h002
`define DT2_EXTRA 12'h001

`endif

// file: rtl/pstage_pkg.sv
// Purpose: Types shared by the power-stage files
// Assumes: Constants live in pstage_defines.svh
// Notes: Field order of each struct is its register bit order, msb first
package pstage_pkg;

  typedef enum logic [1:0] {
    RAMP_ONE,
    RAMP_TWO,
    RAMP_FOUR,
    RAMP_SPARE
  } ramp_e;

  typedef enum logic [1:0] {
    PH_DEAD0,
    PH_ON0,
    PH_DEAD1,
    PH_ON1
  } phase_e;

  typedef struct packed {
    ramp_e ramp;
    logic auto_update_on_b_write;
    logic lock;
    logic run;
  } config_s;

  typedef struct packed {
    logic out_active_high;
    logic part_b_input_select_hi;
    logic part_a_input_select_hi;
    logic en_one;
    logic en_zero;
  } out_cfg_s;

  typedef struct packed {
    logic async_output_kill;
    logic part_input_select_lo;
    logic filter_en;
    logic input_polarity;
    logic [3:0] input_mode_field;
  } in_ctl_s;

  typedef struct packed {
    logic [11:0] set_a;
    logic [11:0] rst_a;
    logic [11:0] set_b;
    logic [11:0] rst_b;
    out_cfg_s out_cfg;
  } wave_s;

endpackage

// file: rtl/input_unit.sv
// Purpose: One part's input module: source pick, sync, filter, sense, event and async kill
// Assumes: Raw sources are asynchronous to sys_clk_i
// Notes: Kill path is combinational so it works with the clock stopped
`include "pstage_defines.svh"

module input_unit (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic shared_pin_i,
  input wire logic comparator_i,
  input wire logic own_pin_i,
  input wire logic select_hi_i,
  input wire pstage_pkg::in_ctl_s ctl_i,
  output logic event_o,
  output logic retrig_o,
  output logic level_o,
  output logic kill_o
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic filt;
    logic [1:0] filt_cnt;
    logic prev_active;
  } unit_state_s;

  unit_state_s st_r;
  unit_state_s st_nxt;
  logic raw_sel;
  logic level;
  logic active;
  logic edge_mode;
  logic level_mode;

  // Source pick; select bits are static config so the mux glitch is harmless
  assign raw_sel = select_hi_i ? own_pin_i
                 : (ctl_i.part_input_select_lo ? comparator_i : shared_pin_i);
  assign edge_mode = (ctl_i.input_mode_field == `MODE_EDGE_RETRIG)
                  || (ctl_i.input_mode_field == `MODE_FIX_RETRIG)
                  || (ctl_i.input_mode_field == `MODE_FIX_RETRIG_OFF);
  // Reserved codes fall in neither class and so do nothing
  assign level_mode = (ctl_i.input_mode_field != `MODE_NONE)
                   && (ctl_i.input_mode_field <= `MODE_LAST_LEVEL);
  assign level = ctl_i.filter_en ? st_r.filt : st_r.sync2;
  assign active = (level == ctl_i.input_polarity);

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = raw_sel;
    st_nxt.sync2 = st_r.sync1;
    if (st_r.sync2 == st_r.filt) begin
      st_nxt.filt_cnt = 2'h0;
    end else if (st_r.filt_cnt == `FILT_LAST) begin
      st_nxt.filt = st_r.sync2;
      st_nxt.filt_cnt = 2'h0;
    end else begin
      st_nxt.filt_cnt = st_r.filt_cnt + 2'h1;
    end
    st_nxt.prev_active = active;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign event_o = edge_mode ? (active && !st_r.prev_active) : 1'b0;
  assign retrig_o = edge_mode;
  assign level_o = level_mode && active;
  // Unsynchronised kill from the raw pin: clockless protection
  assign kill_o = ((raw_sel == ctl_i.input_polarity) && (level_mode || edge_mode))
               && (ctl_i.async_output_kill || (ctl_i.filter_en && level_mode));
endmodule

// file: rtl/power_stage_update_and_input_ctrl.sv
// Purpose: Two-output PWM stage with locked value update and two input modules
// Assumes: Single clock sys_clk_i at 40 MHz; register port strobes one cycle long
// Notes: Fault modes are reduced to output deactivation while the input is active
// Function
// - Auto_update_on_b_write: transfer buffers at end of cycle after part B reset write.
// - Auto_update_on_b_write bit change takes effect after first complete cycle.
// - Lock blocks transfer; clearing it transfers all at next end of cycle.
// - Four compares and output config transfer together as one set.
// - Second-level input-select bits act immediately, unsynchronised.
// - Auto_update_on_b_write set overrides the lock bit.
// - Parts A and B each own an input module configured by its control.
// - Two/four ramp: retrigger ends own sub-cycle, starts the opposite.
// - One ramp: retrigger resets the ramp counter to zero.
// - Input source comparator or pin; inactive, level or edge acting.
// - Input A event deactivates output zero early; B does output one.
// - Filter enable inserts four-cycle digital filter, else unfiltered.
// - Filtered level input still kills outputs with a disturbed clock.
// - Async kill bit deactivates outputs clocklessly; normal processing continues.
// - Polarity set means rising edge or high level, else falling or low.
// - Two/four ramp: input A only in part A times, B in part B.
// - One ramp: both inputs act over the whole ramp.
// - Mode field: zero no action, one to nine, and fourteen decoded.
// - Values load at once when stopped, at end of cycle when running.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "pstage_defines.svh"

module power_stage_update_and_input_ctrl (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`DATA_W-1:0] rdata_o,
  input wire logic external_sense_pin_i,
  input wire logic comparator_i,
  input wire logic sense_input_a_i,
  input wire logic sense_input_b_i,
  output logic output_zero_o,
  output logic output_one_o
);

  typedef struct packed {
    pstage_pkg::config_s cfg;
    pstage_pkg::wave_s buf_set;
    pstage_pkg::wave_s work;
    pstage_pkg::in_ctl_s ctl_a;
    pstage_pkg::in_ctl_s ctl_b;
    logic auto_eff;
    logic auto_pend;
    logic auto_seen;
    logic b_written;
    logic pending;
    logic [11:0] cnt;
    pstage_pkg::phase_e phase;
    logic out0;
    logic out1;
    logic [`DATA_W-1:0] rdata;
  } top_state_s;

  top_state_s st_r;
  top_state_s st_nxt;

  logic ev_a;
  logic ev_b;
  logic rt_a;
  logic rt_b;
  logic lvl_a;
  logic lvl_b;
  logic kill_a;
  logic kill_b;
  logic win_a;
  logic win_b;
  logic eoc;
  logic last_tick;
  logic [11:0] dur;
  logic one_ramp;
  logic four_ramp;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Input modules

  // Select-hi bits read straight from the write buffer, bypassing the transfer
  input_unit unit_a (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .shared_pin_i(external_sense_pin_i),
    .comparator_i(comparator_i),
    .own_pin_i(sense_input_a_i),
    .select_hi_i(st_r.buf_set.out_cfg.part_a_input_select_hi),
    .ctl_i(st_r.ctl_a),
    .event_o(ev_a),
    .retrig_o(rt_a),
    .level_o(lvl_a),
    .kill_o(kill_a)
  );

  input_unit unit_b (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .shared_pin_i(external_sense_pin_i),
    .comparator_i(comparator_i),
    .own_pin_i(sense_input_b_i),
    .select_hi_i(st_r.buf_set.out_cfg.part_b_input_select_hi),
    .ctl_i(st_r.ctl_b),
    .event_o(ev_b),
    .retrig_o(rt_b),
    .level_o(lvl_b),
    .kill_o(kill_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ramp timing

  assign one_ramp = (st_r.cfg.ramp == pstage_pkg::RAMP_ONE);
  assign four_ramp = (st_r.cfg.ramp == pstage_pkg::RAMP_FOUR);
  assign win_a = one_ramp || (st_r.phase == pstage_pkg::PH_DEAD0)
              || (st_r.phase == pstage_pkg::PH_ON0);
  assign win_b = one_ramp || (st_r.phase == pstage_pkg::PH_DEAD1)
              || (st_r.phase == pstage_pkg::PH_ON1);

  always_comb begin
    dur = 12'h000;
    case (st_r.phase)
      pstage_pkg::PH_DEAD0: begin
        dur = st_r.work.set_a + (four_ramp ? `DT4_EXTRA : `DT2_EXTRA);
      end
      pstage_pkg::PH_ON0: begin
        dur = four_ramp ? st_r.work.rst_a : st_r.work.rst_a - st_r.work.set_a;
      end
      pstage_pkg::PH_DEAD1: begin
        dur = st_r.work.set_b + (four_ramp ? `DT4_EXTRA : `DT2_EXTRA);
      end
      pstage_pkg::PH_ON1: begin
        dur = four_ramp ? st_r.work.rst_b : st_r.work.rst_b - st_r.work.set_b;
      end
      default: begin
        dur = 12'h000;
      end
    endcase
  end

  // A zero duration is treated as one tick so the phase always advances
  assign last_tick = one_ramp ? (st_r.cnt >= st_r.work.rst_b)
                   : (st_r.cnt + 12'h001 >= dur);
  assign eoc = st_r.cfg.run && last_tick
            && (one_ramp || (st_r.phase == pstage_pkg::PH_ON1));

  ////////////////////////////////////////////////////////////////////////////
  // Update decision

  always_comb begin
    take = 1'b0;
    if (!st_r.cfg.run) begin
      take = 1'b1;
    end else if (eoc) begin
      if (st_r.auto_eff) begin
        take = st_r.b_written;
      end else if (!st_r.cfg.lock) begin
        take = st_r.pending;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = '0;

    if (take) begin
      st_nxt.work = st_r.buf_set;
      st_nxt.pending = 1'b0;
      st_nxt.b_written = 1'b0;
    end

    // Auto_update_on_b_write choice settles at the end of the first full cycle after writing
    if (eoc && st_r.auto_pend) begin
      if (st_r.auto_seen) begin
        st_nxt.auto_eff = st_r.cfg.auto_update_on_b_write;
        st_nxt.auto_pend = 1'b0;
      end else begin
        st_nxt.auto_seen = 1'b1;
      end
    end else if (!st_r.cfg.run) begin
      st_nxt.auto_eff = st_r.cfg.auto_update_on_b_write;
      st_nxt.auto_pend = 1'b0;
    end

    if (!st_r.cfg.run) begin
      st_nxt.cnt = 12'h000;
      st_nxt.phase = pstage_pkg::PH_DEAD0;
    end else if (one_ramp) begin
      if ((rt_a && ev_a && win_a) || (rt_b && ev_b && win_b) || last_tick) begin
        st_nxt.cnt = 12'h000;
      end else begin
        st_nxt.cnt = st_r.cnt + 12'h001;
      end
    end else if (rt_a && ev_a && win_a) begin
      st_nxt.cnt = 12'h000;
      st_nxt.phase = pstage_pkg::PH_DEAD1;
    end else if (rt_b && ev_b && win_b) begin
      st_nxt.cnt = 12'h000;
      st_nxt.phase = pstage_pkg::PH_DEAD0;
    end else if (last_tick) begin
      st_nxt.cnt = 12'h000;
      case (st_r.phase)
        pstage_pkg::PH_DEAD0: st_nxt.phase = pstage_pkg::PH_ON0;
        pstage_pkg::PH_ON0: st_nxt.phase = pstage_pkg::PH_DEAD1;
        pstage_pkg::PH_DEAD1: st_nxt.phase = pstage_pkg::PH_ON1;
        pstage_pkg::PH_ON1: st_nxt.phase = pstage_pkg::PH_DEAD0;
        default: st_nxt.phase = pstage_pkg::PH_DEAD0;
      endcase
    end else begin
      st_nxt.cnt = st_r.cnt + 12'h001;
    end

    // Raw waveform levels, before input gating and polarity
    if (!st_r.cfg.run) begin
      st_nxt.out0 = 1'b0;
      st_nxt.out1 = 1'b0;
    end else if (one_ramp) begin
      st_nxt.out0 = (st_nxt.cnt >= st_nxt.work.set_a) && (st_nxt.cnt < st_nxt.work.rst_a);
      st_nxt.out1 = (st_nxt.cnt >= st_nxt.work.set_b) && (st_nxt.cnt < st_nxt.work.rst_b);
    end else begin
      st_nxt.out0 = (st_nxt.phase == pstage_pkg::PH_ON0);
      st_nxt.out1 = (st_nxt.phase == pstage_pkg::PH_ON1);
    end
    // Level faults hold the output off while active inside the window
    if (lvl_a && win_a) begin
      st_nxt.out0 = 1'b0;
    end
    if (lvl_b && win_b) begin
      st_nxt.out1 = 1'b0;
    end

    if (wr_i) begin
      case (addr_i)
        `OFF_CONFIG: begin
          st_nxt.cfg = pstage_pkg::config_s'(wdata_i[4:0]);
          if (wdata_i[2] != st_r.cfg.auto_update_on_b_write) begin
            st_nxt.auto_pend = 1'b1;
            st_nxt.auto_seen = 1'b0;
          end
        end
        `OFF_SET_A: begin
          st_nxt.buf_set.set_a = wdata_i[11:0];
          st_nxt.pending = 1'b1;
        end
        `OFF_RST_A: begin
          st_nxt.buf_set.rst_a = wdata_i[11:0];
          st_nxt.pending = 1'b1;
        end
        `OFF_SET_B: begin
          st_nxt.buf_set.set_b = wdata_i[11:0];
          st_nxt.pending = 1'b1;
        end
        `OFF_RST_B: begin
          st_nxt.buf_set.rst_b = wdata_i[11:0];
          st_nxt.pending = 1'b1;
          st_nxt.b_written = 1'b1;
        end
        `OFF_OUT_CFG: begin
          st_nxt.buf_set.out_cfg = pstage_pkg::out_cfg_s'(wdata_i[4:0]);
          st_nxt.pending = 1'b1;
        end
        `OFF_IN_CTL_A: st_nxt.ctl_a = pstage_pkg::in_ctl_s'(wdata_i[7:0]);
        `OFF_IN_CTL_B: st_nxt.ctl_b = pstage_pkg::in_ctl_s'(wdata_i[7:0]);
        default: begin
        end
      endcase
    end

    if (rd_i) begin
      case (addr_i)
        `OFF_CONFIG: st_nxt.rdata = {11'h000, st_r.cfg};
        `OFF_SET_A: st_nxt.rdata = {4'h0, st_r.buf_set.set_a};
        `OFF_RST_A: st_nxt.rdata = {4'h0, st_r.buf_set.rst_a};
        `OFF_SET_B: st_nxt.rdata = {4'h0, st_r.buf_set.set_b};
        `OFF_RST_B: st_nxt.rdata = {4'h0, st_r.buf_set.rst_b};
        `OFF_OUT_CFG: st_nxt.rdata = {11'h000, st_r.buf_set.out_cfg};
        `OFF_IN_CTL_A: st_nxt.rdata = {8'h00, st_r.ctl_a};
        `OFF_IN_CTL_B: st_nxt.rdata = {8'h00, st_r.ctl_b};
        `OFF_STATUS: begin
          st_nxt.rdata = {st_r.auto_eff, st_r.pending, st_r.phase, st_r.cnt};
        end
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.cfg <= `RST_CONFIG;
      st_r.buf_set.out_cfg <= `RST_OUT_CFG;
      st_r.work.out_cfg <= `RST_OUT_CFG;
      st_r.ctl_a <= `RST_IN_CTL;
      st_r.ctl_b <= `RST_IN_CTL;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  // Kill bypasses the flops so a stopped clock cannot hold a switch on
  assign output_zero_o = ((st_r.out0 && st_r.work.out_cfg.en_zero) && !kill_a)
                       == st_r.work.out_cfg.out_active_high;
  assign output_one_o = ((st_r.out1 && st_r.work.out_cfg.en_one) && !kill_b)
                      == st_r.work.out_cfg.out_active_high;
  assign rdata_o = st_r.rdata;
endmodule

// file: sim/pstage_sva.sv
// Purpose: Port-level checks for the power-stage block
// Assumes: Output polarity bit stays at its reset value
// Notes: Shadows the write buffer from the observed register writes
`include "pstage_defines.svh"
module pstage_sva (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [`DATA_W-1:0] rdata_o,
  input wire logic external_sense_pin_i,
  input wire logic comparator_i,
  input wire logic sense_input_a_i,
  input wire logic sense_input_b_i,
  input wire logic output_zero_o,
  input wire logic output_one_o
);
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [15:0] buf_r [0:7];
  logic [15:0] exp_rd_r;
  pstage_pkg::in_ctl_s ca;
  pstage_pkg::in_ctl_s cb;
  pstage_pkg::out_cfg_s oc;
  logic act_a, act_b, hi;
  function automatic logic [15:0] keep(input logic [3:0] a);
    return (a == 4'h0 || a == 4'h5) ? 16'h001F : (a > 4'h5) ? 16'h00FF : 16'h0FFF;
  endfunction
  function automatic logic lvl(input logic [3:0] m);
    return m inside {[4'h1:4'h7]};
  endfunction
  function automatic logic legal(input logic [3:0] m);
    return lvl(m) || m inside {4'h8, 4'h9, 4'hE};
  endfunction
  ////////////////////////////////////////
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 8; i++) begin
        buf_r[i] <= (i == 5) ? 16'h0013 : 16'h0000;
      end
      exp_rd_r <= 16'h0000;
    end else begin
      if (wr_i && addr_i < `OFF_STATUS) begin
        buf_r[addr_i[2:0]] <= wdata_i & keep(addr_i);
      end
      if (rd_i) begin
        exp_rd_r <= buf_r[addr_i[2:0]];
      end
    end
  end
  assign ca = buf_r[6][7:0];
  assign cb = buf_r[7][7:0];
  assign oc = buf_r[5][4:0];
  assign hi = oc.out_active_high;
  // Source pick follows the buffer: second-level selects act at once
  assign act_a = ca.input_polarity == (oc.part_a_input_select_hi ? sense_input_a_i :
    ca.part_input_select_lo ? comparator_i : external_sense_pin_i);
  assign act_b = cb.input_polarity == (oc.part_b_input_select_hi ? sense_input_b_i :
    cb.part_input_select_lo ? comparator_i : external_sense_pin_i);
  ////////////////////////////////////////
  sequence buf_rd;
    rd_i && addr_i inside {[`OFF_SET_A:`OFF_OUT_CFG]};
  endsequence
  sequence stopped2;
    !buf_r[0][0] && hi ##1 !buf_r[0][0] && hi;
  endsequence
  idle_rdata_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_rd_a: assert property (rd_i && addr_i > `OFF_STATUS |=> rdata_o == 16'h0000)
    else $error("unmapped read returned nonzero data");
  readback_a: assert property (buf_rd |=> rdata_o == exp_rd_r)
    else $error("buffered register read back wrong");
  kill_a_a: assert property (act_a && legal(ca.input_mode_field) &&
    ca.async_output_kill && hi |-> !output_zero_o)
    else $error("async kill did not drop output zero");
  kill_b_a: assert property (act_b && legal(cb.input_mode_field) &&
    cb.async_output_kill && hi |-> !output_one_o)
    else $error("async kill did not drop output one");
  filt_kill_a: assert property (act_a && lvl(ca.input_mode_field) &&
    ca.filter_en && hi |-> !output_zero_o)
    else $error("filtered level input did not drop output zero");
  filt_kill_b_a: assert property (act_b && lvl(cb.input_mode_field) &&
    cb.filter_en && hi |-> !output_one_o)
    else $error("filtered level input did not drop output one");
  stop_quiet_a: assert property (stopped2 |-> !output_zero_o && !output_one_o)
    else $error("outputs active while stopped");
endmodule
bind power_stage_update_and_input_ctrl pstage_sva chk (.sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .external_sense_pin_i(external_sense_pin_i),
  .comparator_i(comparator_i), .sense_input_a_i(sense_input_a_i),
  .sense_input_b_i(sense_input_b_i), .output_zero_o(output_zero_o),
  .output_one_o(output_one_o));

// file: sim/sense_env.sv
// Purpose: Far side model: sense pins and analog comparator
// Assumes: Pin levels come from the bench
// Notes: Comparator mirrors the shared node inverted; part A pin idles low
module sense_env (
  input wire logic pin_lvl_i,
  input wire logic b_lvl_i,
  output logic external_sense_pin_o,
  output logic comparator_o,
  output logic sense_input_a_o,
  output logic sense_input_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign external_sense_pin_o = pin_lvl_i;
  assign comparator_o = ~pin_lvl_i;
  assign sense_input_a_o = 1'b0;
  assign sense_input_b_o = b_lvl_i;
endmodule

// file: sim/power_stage_update_and_input_ctrl_bench.sv
// Purpose: Self-checking bench for the power-stage block
// Assumes: One-ramp mode except the four-ramp test, output polarity left active high
// Notes: Output counts span one whole PWM period
`include "pstage_defines.svh"
module power_stage_update_and_input_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [`ADDR_W-1:0] addr_i = 4'h0;
  logic [`DATA_W-1:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [`DATA_W-1:0] rdata_o;
  logic pin_lvl = 1'b0;
  logic b_lvl = 1'b1;
  logic ext_pin, cmp_o, in_a, in_b, out0, out1;
  logic [15:0] d, c0, c1;
  int miscompares = 0;
  int n_tests = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  sense_env env (.pin_lvl_i(pin_lvl), .b_lvl_i(b_lvl), .external_sense_pin_o(ext_pin),
    .comparator_o(cmp_o), .sense_input_a_o(in_a), .sense_input_b_o(in_b));
  power_stage_update_and_input_ctrl dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .external_sense_pin_i(ext_pin), .comparator_i(cmp_o), .sense_input_a_i(in_a),
    .sense_input_b_i(in_b), .output_zero_o(out0), .output_one_o(out1));
  ////////////////////////////////////////
  task automatic final_report();
    $display("Counts: %0d compared, %0d mismatched", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  // Unknown outputs spoil the count, so a zero count cannot hide them
  task automatic outs(input logic [15:0] e0, input logic [15:0] e1);
    c0 = 16'h0000;
    c1 = 16'h0000;
    repeat (10) begin
      @(negedge sys_clk_i);
      c0 += 16'(out0 === 1'b1) + ($isunknown(out0) ? 16'h0100 : 16'h0000);
      c1 += 16'(out1 === 1'b1) + ($isunknown(out1) ? 16'h0100 : 16'h0000);
    end
    cmp16(c0, e0);
    cmp16(c1, e1);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rd(`OFF_OUT_CFG);
    cmp16(d, 16'h0013);
    rd(`OFF_SET_A);
    cmp16(d, 16'h0000);
    rd(4'hC);
    cmp16(d, 16'h0000);
    $display("t_reset done");
  endtask
  task automatic t_load();
    wr(`OFF_SET_A, 16'h0002);
    wr(`OFF_RST_A, 16'h0006);
    wr(`OFF_SET_B, 16'h0007);
    wr(`OFF_RST_B, 16'h0009);
    wr(`OFF_CONFIG, 16'h0001);
    idle(2);
    outs(16'h4, 16'h2);
    $display("t_load done");
  endtask
  task automatic t_lock();
    wr(`OFF_CONFIG, 16'h0003);
    wr(`OFF_RST_A, 16'h0008);
    wr(`OFF_SET_B, 16'h0008);
    idle(30);
    outs(16'h4, 16'h2);
    wr(`OFF_CONFIG, 16'h0001);
    idle(25);
    outs(16'h6, 16'h1);
    $display("t_lock done");
  endtask
  task automatic t_auto();
    wr(`OFF_CONFIG, 16'h0007);
    rd(`OFF_STATUS);
    cmp16({15'h0, d[15]}, 16'h0);
    idle(30);
    rd(`OFF_STATUS);
    cmp16({15'h0, d[15]}, 16'h1);
    wr(`OFF_RST_A, 16'h0004);
    idle(30);
    outs(16'h6, 16'h1);
    wr(`OFF_RST_B, 16'h0009);
    idle(30);
    outs(16'h2, 16'h1);
    wr(`OFF_CONFIG, 16'h0001);
    idle(30);
    $display("t_auto done");
  endtask
  task automatic t_modes();
    wr(`OFF_OUT_CFG, 16'h001B);
    pin_lvl <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      wr(`OFF_IN_CTL_A, 16'h0030 | 16'(i));
      wr(`OFF_IN_CTL_B, 16'h0030 | 16'(i));
      idle(8);
      if (i >= 1 && i <= 7) begin
        outs(16'h0, 16'h0);
      end else begin
        outs(16'h2, 16'h1);
      end
    end
    wr(`OFF_IN_CTL_A, 16'h0000);
    wr(`OFF_IN_CTL_B, 16'h0000);
    pin_lvl <= 1'b0;
    $display("t_modes done");
  endtask
  task automatic t_kill();
    b_lvl <= 1'b0;
    wr(`OFF_IN_CTL_A, 16'h00D4);
    wr(`OFF_IN_CTL_B, 16'h0084);
    idle(2);
    outs(16'h0, 16'h0);
    b_lvl <= 1'b1;
    pin_lvl <= 1'b1;
    idle(6);
    outs(16'h2, 16'h1);
    wr(`OFF_IN_CTL_A, 16'h0000);
    wr(`OFF_IN_CTL_B, 16'h0000);
    pin_lvl <= 1'b0;
    $display("t_kill done");
  endtask
  // Pulse the shared pin mid-phase; expect {phase, count restarted}
  task automatic pulse(input int w, input logic [1:0] ph, input logic [15:0] exp);
    int k;
    d = 16'h0000;
    for (k = 0; k < 300 && !(d[13:12] == ph && d[11:0] > 12'h028 && d[11:0] < 12'h064);
         k++) begin
      rd(`OFF_STATUS);
    end
    if (k == 300) begin
      miscompares++;
      final_report();
    end else begin
      pin_lvl <= 1'b1;
      idle(w);
      pin_lvl <= 1'b0;
      idle(4);
      rd(`OFF_STATUS);
      cmp16({13'h0000, d[13:12], d[11:0] < 12'h014}, exp);
    end
  endtask
  task automatic t_retrig();
    wr(`OFF_RST_B, 16'h00C8);
    idle(30);
    wr(`OFF_IN_CTL_A, 16'h0038);
    pulse(2, 2'h0, 16'h0000);
    pulse(6, 2'h0, 16'h0001);
    $display("t_retrig done");
  endtask
  // Input A is refused in part B time, and in part A time jumps to part B
  task automatic t_four();
    wr(`OFF_CONFIG, 16'h0000);
    wr(`OFF_SET_A, 16'h0000);
    wr(`OFF_RST_A, 16'h0080);
    wr(`OFF_SET_B, 16'h0000);
    wr(`OFF_RST_B, 16'h0080);
    wr(`OFF_CONFIG, 16'h0011);
    wr(`OFF_IN_CTL_A, 16'h0018);
    pulse(2, 2'h3, 16'h0006);
    pulse(2, 2'h1, 16'h0007);
    $display("t_four done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_load();
    t_lock();
    t_auto();
    t_modes();
    t_kill();
    t_retrig();
    t_four();
    final_report();
  end
  initial begin
    #500us;
    miscompares++;
    final_report();
  end
endmodule
